// ### core/umc_pkg.sv
// constants, field positions and carrier types of the modem control block
// assumes one 25 MHz clock and a uart core beside it that owns the fifos
// Contract
// - dtr pin low while control bit 0 set outside loopback; loopback feeds status bit 5
// - rts pin follows control bit 1 unless auto rts owns it; held high in loopback
// - fifo ready register readable only while control bit 2 set
// - control bit 3 enables the interrupt pin driver; loopback feeds status 7
// - control bit 4 loops control 3:0 into status and tx into rx
// - control bit 5 enables xon-any
// - threshold and trigger registers writable only while control bit 6 set
// - control bit 7 selects divide by four; loaded with inverse strap
// - control bits 7:5 writable only with enhanced functions enabled
// - status bits 0,1,3 flag cts, dsr, cd changes; read clears
// - status bit 2 flags ring falling edge, rising edge in loopback; read clears
// - status bits 7:4 show cd, ri, dsr, cts active or loopback bits
// - modem inputs are active low pins, active high inside
// - enable bits 3:0 gate rx data, tx, line status, modem interrupts
// - enable bit 4 sleep; bits 5,6,7 gate xoff, rts, cts interrupts
// - enable bits 7:4 writable only with enhanced functions enabled
// - re-enabling tx interrupt while below threshold raises a new one
// - ident register read only; bit 0 low while any enabled source pending
// - ident bit 4 on xoff or special char, bit 5 on cts/rts rise
// - ident bits 7:6 both mirror the fifo enable bit
// - ident bits 5:0 give the highest priority pending source code
// - interrupt output goes active one cycle after an enabled source is pending
// - enhanced feature bit 4 is write enable for gated fields
// - fifo setup bit 0 enables both fifos
package umc_pkg;

   localparam int unsigned CLK_HZ = 25_000_000;

   // byte addresses on the register bus
   localparam logic [4:0] OFS_MODEM_CTRL = 5'h00;
   localparam logic [4:0] OFS_MODEM_STAT = 5'h04;
   localparam logic [4:0] OFS_INT_ENABLE = 5'h08;
   localparam logic [4:0] OFS_INT_IDENT  = 5'h0c;
   localparam logic [4:0] OFS_ENH_FEAT   = 5'h10;
   localparam logic [4:0] OFS_FIFO_SETUP = 5'h14;
   localparam logic [4:0] OFS_FIFO_READY = 5'h18;
   localparam logic [4:0] OFS_FLOW_TRIG  = 5'h1c;

   // modem control bits
   localparam int MC_DTR     = 0;
   localparam int MC_RTS     = 1;
   localparam int MC_FRDY_EN = 2;
   localparam int MC_IRQ_EN  = 3;
   localparam int MC_LOOP    = 4;
   localparam int MC_XON_ANY = 5;
   localparam int MC_FLOW_AC = 6;
   localparam int MC_DIV4    = 7;
   localparam logic [7:0] MC_GATED_MASK = 8'he0;
   localparam logic [7:0] MC_RESET      = 8'h00;

   // interrupt enable bits
   localparam int IE_RX_DATA = 0;
   localparam int IE_TX      = 1;
   localparam int IE_LINE    = 2;
   localparam int IE_MODEM   = 3;
   localparam int IE_SLEEP   = 4;
   localparam int IE_XOFF    = 5;
   localparam int IE_RTS     = 6;
   localparam int IE_CTS     = 7;
   localparam logic [7:0] IE_GATED_MASK = 8'hf0;
   localparam logic [7:0] IE_RESET      = 8'h00;

   // enhanced feature and fifo setup bits
   localparam int EF_ENH      = 4;
   localparam int EF_AUTO_RTS = 6;
   localparam int FS_FIFO_EN  = 0;
   localparam int FS_RX_CLR   = 1;
   localparam int FS_TX_CLR   = 2;
   localparam logic [7:0] FS_GATED_MASK = 8'h30;
   localparam logic [7:0] FS_PULSE_MASK = 8'h06;
   localparam logic [7:0] REG8_RESET    = 8'h00;

   // line order inside the four-bit modem vectors: cts, dsr, ri, cd
   localparam int LN_CTS = 0;
   localparam int LN_DSR = 1;
   localparam int LN_RI  = 2;
   localparam int LN_CD  = 3;
   localparam logic [3:0] PIN_IDLE = 4'hf;

   // identification codes, bits 5:0
   localparam logic [5:0] ID_NONE    = 6'h01;
   localparam logic [5:0] ID_LINE    = 6'h06;
   localparam logic [5:0] ID_TIMEOUT = 6'h0c;
   localparam logic [5:0] ID_RX_DATA = 6'h04;
   localparam logic [5:0] ID_TX      = 6'h02;
   localparam logic [5:0] ID_MODEM   = 6'h00;
   localparam logic [5:0] ID_XOFF    = 6'h10;
   localparam logic [5:0] ID_CTSRTS  = 6'h20;

   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } umc_modem_pins_type;

   typedef struct packed {
      logic       line_err;
      logic       rx_timeout;
      logic       rx_data;
      logic       tx_below;
      logic       xoff_det;
      logic       auto_rts_n;
      logic [7:0] fifo_ready;
   } umc_core_stat_type;

   typedef struct packed {
      logic       loopback;
      logic       xon_any;
      logic       clk_div4;
      logic       sleep_en;
      logic [7:0] enh_feat;
      logic [7:0] fifo_setup;
      logic [7:0] flow_thresh;
      logic [7:0] trig_level;
   } umc_core_ctl_type;

endpackage : umc_pkg

// ### core/umc_sync.sv
// three-stage input synchroniser with agreement filter
// assumes asynchronous pin inputs and a synchronous active high reset
module umc_sync #(
   parameter int         W       = 4,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] lvl_q;

   // first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
      end else begin
         s1_q <= i_async;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // accept a bit once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lvl_q <= RST_VAL;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
      end
   end

   assign o_level = lvl_q;

endmodule : umc_sync

// ### core/umc_modem_ctrl.sv
// modem control, modem status and interrupt logic of one uart channel
// assumes an avalon-mm master on i_clk and a uart core supplying status
module umc_modem_ctrl (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst,
   input  wire logic [4:0]                 i_avs_address,
   input  wire logic                       i_avs_read,
   input  wire logic                       i_avs_write,
   input  wire logic [31:0]                i_avs_writedata,
   input  wire logic [3:0]                 i_avs_byteenable,
   output logic      [31:0]                o_avs_readdata,
   output logic                            o_avs_waitrequest,
   input  wire umc_pkg::umc_modem_pins_type i_modem,
   input  wire logic                       i_clock_divide_select_pin,
   input  wire umc_pkg::umc_core_stat_type i_core,
   output umc_pkg::umc_core_ctl_type       o_ctl,
   output logic                            o_dtr_n,
   output logic                            o_rts_n,
   output logic                            o_irq,
   output logic                            o_irq_oe
);

   // register bus state
   logic        ack_q;
   logic        req;
   logic        cap;
   logic        take;
   logic [31:0] rdata_q;

   // software registers
   logic [7:0]  mc_q;
   logic [7:0]  ie_q;
   logic [7:0]  ef_q;
   logic [7:0]  fs_q;
   logic [7:0]  tcr_q;
   logic [7:0]  tlr_q;
   logic        strap_pend_q;

   // modem lines
   umc_pkg::umc_modem_pins_type pins_s;
   logic [3:0]  line_act;
   logic [3:0]  prev_q;
   logic [3:0]  delta_q;
   logic [3:0]  delta_set;
   logic [7:0]  stat_val;

   // interrupt sources
   logic        tx_pend_q;
   logic        tx_below_q;
   logic        xoff_q;
   logic        cr_q;
   logic        rts_prev_q;
   logic        rts_n;
   logic        tx_reen;
   logic [5:0]  id_code;
   logic [7:0]  id_val;
   logic        irq_q;
   logic        loop;
   logic        enh;

   function automatic logic hit(input logic [4:0] a,
                                input logic [4:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   assign loop = mc_q[umc_pkg::MC_LOOP];
   assign enh  = ef_q[umc_pkg::EF_ENH];

   // ---------------- avalon slave: one wait cycle per access
   assign req  = i_avs_read | i_avs_write;
   assign cap  = req & ~ack_q;
   assign take = req & ack_q;
   assign o_avs_waitrequest = req & ~ack_q;
   assign o_avs_readdata    = rdata_q;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cap;
      end
   end

   // read data captured on the first edge, held through the accept edge
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         rdata_q <= '0;
      end else if (cap & i_avs_read) begin
         rdata_q <= '0;
         if (hit(i_avs_address, umc_pkg::OFS_MODEM_CTRL)) begin
            rdata_q[7:0] <= mc_q;
         end else if (hit(i_avs_address, umc_pkg::OFS_MODEM_STAT)) begin
            rdata_q[7:0] <= stat_val;
         end else if (hit(i_avs_address, umc_pkg::OFS_INT_ENABLE)) begin
            rdata_q[7:0] <= ie_q;
         end else if (hit(i_avs_address, umc_pkg::OFS_INT_IDENT)) begin
            rdata_q[7:0] <= id_val;
         end else if (hit(i_avs_address, umc_pkg::OFS_ENH_FEAT)) begin
            rdata_q[7:0] <= ef_q;
         end else if (hit(i_avs_address, umc_pkg::OFS_FIFO_SETUP)) begin
            rdata_q[7:0] <= fs_q;
         end else if (hit(i_avs_address, umc_pkg::OFS_FIFO_READY)) begin
            if (mc_q[umc_pkg::MC_FRDY_EN] & ~loop) begin
               rdata_q[7:0] <= i_core.fifo_ready;
            end
         end else if (hit(i_avs_address, umc_pkg::OFS_FLOW_TRIG)) begin
            rdata_q[15:0] <= {tlr_q, tcr_q};
         end
      end
   end

   // ---------------- modem control register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mc_q         <= umc_pkg::MC_RESET;
         strap_pend_q <= 1'b1;
      end else begin
         strap_pend_q <= 1'b0;
         if (take & i_avs_write & i_avs_byteenable[0] &
             hit(i_avs_address, umc_pkg::OFS_MODEM_CTRL)) begin
            mc_q[4:0] <= i_avs_writedata[4:0];
            if (enh) begin
               mc_q[7:5] <= i_avs_writedata[7:5];
            end
         end
         if (strap_pend_q) begin
            mc_q[umc_pkg::MC_DIV4] <= ~i_clock_divide_select_pin;
         end
      end
   end

   // ---------------- interrupt enable register
   assign tx_reen = take & i_avs_write & i_avs_byteenable[0] &
                    hit(i_avs_address, umc_pkg::OFS_INT_ENABLE) &
                    i_avs_writedata[umc_pkg::IE_TX] &
                    ~ie_q[umc_pkg::IE_TX];

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ie_q <= umc_pkg::IE_RESET;
      end else if (take & i_avs_write & i_avs_byteenable[0] &
                   hit(i_avs_address, umc_pkg::OFS_INT_ENABLE)) begin
         ie_q[3:0] <= i_avs_writedata[3:0];
         if (enh) begin
            ie_q[7:4] <= i_avs_writedata[7:4];
         end
      end
   end

   // ---------------- enhanced feature register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ef_q <= umc_pkg::REG8_RESET;
      end else if (take & i_avs_write & i_avs_byteenable[0] &
                   hit(i_avs_address, umc_pkg::OFS_ENH_FEAT)) begin
         ef_q <= i_avs_writedata[7:0];
      end
   end

   // ---------------- fifo setup: clear bits self-clear after one cycle
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         fs_q <= umc_pkg::REG8_RESET;
      end else if (take & i_avs_write & i_avs_byteenable[0] &
                   hit(i_avs_address, umc_pkg::OFS_FIFO_SETUP)) begin
         fs_q[umc_pkg::FS_FIFO_EN] <=
            i_avs_writedata[umc_pkg::FS_FIFO_EN];
         fs_q[umc_pkg::FS_RX_CLR]  <= i_avs_writedata[umc_pkg::FS_RX_CLR];
         fs_q[umc_pkg::FS_TX_CLR]  <= i_avs_writedata[umc_pkg::FS_TX_CLR];
         fs_q[3]   <= i_avs_writedata[3];
         fs_q[7:6] <= i_avs_writedata[7:6];
         if (enh) begin
            fs_q[5:4] <= i_avs_writedata[5:4];
         end
      end else begin
         fs_q <= fs_q & ~umc_pkg::FS_PULSE_MASK;
      end
   end

   // ---------------- threshold and trigger levels
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tcr_q <= umc_pkg::REG8_RESET;
         tlr_q <= umc_pkg::REG8_RESET;
      end else if (take & i_avs_write & enh & mc_q[umc_pkg::MC_FLOW_AC] &
                   hit(i_avs_address, umc_pkg::OFS_FLOW_TRIG)) begin
         if (i_avs_byteenable[0]) begin
            tcr_q <= i_avs_writedata[7:0];
         end
         if (i_avs_byteenable[1]) begin
            tlr_q <= i_avs_writedata[15:8];
         end
      end
   end

   // ---------------- modem inputs
   umc_sync #(
      .W       (4),
      .RST_VAL (umc_pkg::PIN_IDLE)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (i_modem),
      .o_level (pins_s)
   );

   // active high line values, from pins or from control bits in loopback
   always_comb begin
      if (loop) begin
         line_act[umc_pkg::LN_CTS] = mc_q[umc_pkg::MC_RTS];
         line_act[umc_pkg::LN_DSR] = mc_q[umc_pkg::MC_DTR];
         line_act[umc_pkg::LN_RI]  = mc_q[umc_pkg::MC_FRDY_EN];
         line_act[umc_pkg::LN_CD]  = mc_q[umc_pkg::MC_IRQ_EN];
      end else begin
         line_act[umc_pkg::LN_CTS] = ~pins_s.cts_n;
         line_act[umc_pkg::LN_DSR] = ~pins_s.dsr_n;
         line_act[umc_pkg::LN_RI]  = ~pins_s.ri_n;
         line_act[umc_pkg::LN_CD]  = ~pins_s.cd_n;
      end
   end

   // change detection per line
   always_comb begin
      delta_set = prev_q ^ line_act;
      if (loop) begin
         delta_set[umc_pkg::LN_RI] = line_act[umc_pkg::LN_RI] &
                                     ~prev_q[umc_pkg::LN_RI];
      end else begin
         delta_set[umc_pkg::LN_RI] = ~line_act[umc_pkg::LN_RI] &
                                     prev_q[umc_pkg::LN_RI];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         prev_q <= '0;
      end else begin
         prev_q <= line_act;
      end
   end

   // change flags clear on a status read; a new change wins
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         delta_q <= '0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (delta_set[i]) begin
               delta_q[i] <= 1'b1;
            end else if (cap & i_avs_read &
                         hit(i_avs_address, umc_pkg::OFS_MODEM_STAT)) begin
               delta_q[i] <= 1'b0;
            end
         end
      end
   end

   assign stat_val = {line_act, delta_q};

   // ---------------- modem outputs
   always_comb begin
      if (ef_q[umc_pkg::EF_AUTO_RTS]) begin
         rts_n = i_core.auto_rts_n;
      end else begin
         rts_n = ~mc_q[umc_pkg::MC_RTS];
      end
   end

   // pins held inactive while looped back
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_dtr_n <= 1'b1;
         o_rts_n <= 1'b1;
      end else begin
         o_dtr_n <= loop | ~mc_q[umc_pkg::MC_DTR];
         o_rts_n <= loop | rts_n;
      end
   end

   // ---------------- interrupt sources
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_below_q <= 1'b0;
         rts_prev_q <= 1'b1;
      end else begin
         tx_below_q <= i_core.tx_below;
         rts_prev_q <= o_rts_n;
      end
   end

   // tx interrupt: on entering below threshold or on re-enable
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         tx_pend_q <= 1'b0;
      end else if ((i_core.tx_below & ~tx_below_q) |
                   (tx_reen & i_core.tx_below)) begin
         tx_pend_q <= 1'b1;
      end else if (~i_core.tx_below |
                   (cap & i_avs_read & (id_code == umc_pkg::ID_TX) &
                    hit(i_avs_address, umc_pkg::OFS_INT_IDENT))) begin
         tx_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         xoff_q <= 1'b0;
      end else if (i_core.xoff_det) begin
         xoff_q <= 1'b1;
      end else if (cap & i_avs_read & (id_code == umc_pkg::ID_XOFF) &
                   hit(i_avs_address, umc_pkg::OFS_INT_IDENT)) begin
         xoff_q <= 1'b0;
      end
   end

   // cts pin or rts pin going inactive
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cr_q <= 1'b0;
      end else if ((ie_q[umc_pkg::IE_CTS] & delta_set[umc_pkg::LN_CTS] &
                    prev_q[umc_pkg::LN_CTS]) |
                   (ie_q[umc_pkg::IE_RTS] & o_rts_n & ~rts_prev_q)) begin
         cr_q <= 1'b1;
      end else if (cap & i_avs_read & (id_code == umc_pkg::ID_CTSRTS) &
                   hit(i_avs_address, umc_pkg::OFS_INT_IDENT)) begin
         cr_q <= 1'b0;
      end
   end

   // priority encoder for the identification code
   always_comb begin
      if (ie_q[umc_pkg::IE_LINE] & i_core.line_err) begin
         id_code = umc_pkg::ID_LINE;
      end else if (ie_q[umc_pkg::IE_RX_DATA] & i_core.rx_timeout) begin
         id_code = umc_pkg::ID_TIMEOUT;
      end else if (ie_q[umc_pkg::IE_RX_DATA] & i_core.rx_data) begin
         id_code = umc_pkg::ID_RX_DATA;
      end else if (ie_q[umc_pkg::IE_TX] & tx_pend_q) begin
         id_code = umc_pkg::ID_TX;
      end else if (ie_q[umc_pkg::IE_MODEM] & |delta_q) begin
         id_code = umc_pkg::ID_MODEM;
      end else if (ie_q[umc_pkg::IE_XOFF] & xoff_q) begin
         id_code = umc_pkg::ID_XOFF;
      end else if (cr_q) begin
         id_code = umc_pkg::ID_CTSRTS;
      end else begin
         id_code = umc_pkg::ID_NONE;
      end
   end

   assign id_val = {{2{fs_q[umc_pkg::FS_FIFO_EN]}}, id_code};

   // interrupt pin: level plus driver enable
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (id_code != umc_pkg::ID_NONE);
      end
   end

   assign o_irq    = irq_q;
   assign o_irq_oe = mc_q[umc_pkg::MC_IRQ_EN];

   // ---------------- control out to the uart core
   always_comb begin
      o_ctl.loopback    = loop;
      o_ctl.xon_any     = mc_q[umc_pkg::MC_XON_ANY];
      o_ctl.clk_div4    = mc_q[umc_pkg::MC_DIV4];
      o_ctl.sleep_en    = ie_q[umc_pkg::IE_SLEEP];
      o_ctl.enh_feat    = ef_q;
      o_ctl.fifo_setup  = fs_q;
      o_ctl.flow_thresh = tcr_q;
      o_ctl.trig_level  = tlr_q;
   end

endmodule : umc_modem_ctrl

// ### tb/umc_modem_peer.sv
// modem side model driving the four handshake pins
// assumes the bench gives the wanted active states on i_act
module umc_modem_peer (
   input  wire logic                   i_clk,
   input  wire logic [3:0]             i_act,
   output umc_pkg::umc_modem_pins_type o_modem
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_modem = umc_pkg::PIN_IDLE;
   // active low on the wire, changed just after an edge
   always @(posedge i_clk) o_modem <= ~i_act;
endmodule : umc_modem_peer

// ### tb/umc_modem_ctrl_checker.sv
// port checker of the modem control block
// assumes a bind onto umc_modem_ctrl, one clock domain
module umc_modem_ctrl_checker (
   input wire logic                      i_clk,
   input wire logic                      i_rst,
   input wire logic [4:0]                i_avs_address,
   input wire logic                      i_avs_read,
   input wire logic                      i_avs_write,
   input wire logic [31:0]               i_avs_writedata,
   input wire logic [3:0]                i_avs_byteenable,
   input wire logic [31:0]               o_avs_readdata,
   input wire logic                      o_avs_waitrequest,
   input wire logic                      i_clock_divide_select_pin,
   input wire umc_pkg::umc_core_ctl_type o_ctl,
   input wire logic                      o_dtr_n,
   input wire logic                      o_rts_n,
   input wire logic                      o_irq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       mc_wr;
   logic [7:0] mc_q;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   assign mc_wr = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
      && i_avs_address == umc_pkg::OFS_MODEM_CTRL;
   always_ff @(posedge i_clk) if (mc_wr) mc_q <= i_avs_writedata[7:0];
   sequence s_mc_wr;
      mc_wr;
   endsequence
   sequence s_rd(logic [4:0] a);
      i_avs_read && !o_avs_waitrequest && i_avs_address == a;
   endsequence
   property p_dtr;
      s_mc_wr |-> ##[1:2] o_dtr_n == !(mc_q[0] && !mc_q[4]);
   endproperty
   property p_rts;
      s_mc_wr ##1 !o_ctl.enh_feat[umc_pkg::EF_AUTO_RTS]
         |-> ##[0:1] o_rts_n == !(mc_q[1] && !mc_q[4]);
   endproperty
   property p_irq_oe;
      s_mc_wr |-> ##[1:2] o_irq_oe == mc_q[3];
   endproperty
   property p_loop;
      s_mc_wr |=> o_ctl.loopback == mc_q[4];
   endproperty
   property p_gate;
      s_mc_wr ##0 !o_ctl.enh_feat[umc_pkg::EF_ENH]
         |=> o_ctl.xon_any == $past(o_ctl.xon_any);
   endproperty
   property p_div4;
      $past(i_rst) |=> o_ctl.clk_div4 == !$past(i_clock_divide_select_pin);
   endproperty
   property p_frdy;
      s_rd(umc_pkg::OFS_FIFO_READY) ##0 o_ctl.loopback
         |-> o_avs_readdata == 32'h0;
   endproperty
   property p_ident;
      s_rd(umc_pkg::OFS_INT_IDENT)
         |-> o_avs_readdata[7:6] == {2{o_ctl.fifo_setup[0]}};
   endproperty
   a_dtr: assert property (p_dtr) else $error("dtr pin wrong");
   a_rts: assert property (p_rts) else $error("rts pin wrong");
   a_irq_oe: assert property (p_irq_oe) else $error("irq oe wrong");
   a_loop: assert property (p_loop) else $error("loopback wrong");
   a_gate: assert property (p_gate) else $error("gated bit changed");
   a_div4: assert property (p_div4) else $error("divide select wrong");
   a_frdy: assert property (p_frdy) else $error("fifo ready leaked");
   a_ident: assert property (p_ident) else $error("ident 7:6 wrong");
endmodule : umc_modem_ctrl_checker
bind umc_modem_ctrl umc_modem_ctrl_checker i_chk (.i_clk, .i_rst,
   .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_clock_divide_select_pin,
   .o_ctl, .o_dtr_n, .o_rts_n, .o_irq_oe);

// ### tb/umc_modem_ctrl_tb.sv
// self-checking bench of the modem control block
// assumes umc_pkg, the modem peer model and the bound checker
module umc_modem_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] A_MC = umc_pkg::OFS_MODEM_CTRL;
   localparam logic [4:0] A_MS = umc_pkg::OFS_MODEM_STAT;
   localparam logic [4:0] A_IE = umc_pkg::OFS_INT_ENABLE;
   localparam logic [4:0] A_ID = umc_pkg::OFS_INT_IDENT;
   localparam logic [4:0] A_EF = umc_pkg::OFS_ENH_FEAT;
   localparam logic [4:0] A_FS = umc_pkg::OFS_FIFO_SETUP;
   localparam logic [4:0] A_FR = umc_pkg::OFS_FIFO_READY;
   localparam logic [4:0] A_FT = umc_pkg::OFS_FLOW_TRIG;
   logic i_clk, i_rst, i_avs_read, i_avs_write, i_clock_divide_select_pin, xoff;
   logic o_avs_waitrequest, o_dtr_n, o_rts_n, o_irq, o_irq_oe;
   logic [4:0]  i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, q[$];
   logic [3:0]  i_avs_byteenable, act, src;
   logic [7:0]  fr;
   logic [5:0]  ids [4] = '{6'h06, 6'h0c, 6'h04, 6'h02};
   umc_pkg::umc_modem_pins_type i_modem;
   umc_pkg::umc_core_stat_type  i_core;
   umc_pkg::umc_core_ctl_type   o_ctl;
   int n_fail, checks, cyc;
   integer seed = 32'h59d4f707;
   assign i_core = {src, xoff, 1'b1, fr};
   umc_modem_ctrl i_dut (.i_clk, .i_rst, .i_avs_address, .i_avs_read,
      .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
      .o_avs_waitrequest, .i_modem, .i_clock_divide_select_pin, .i_core, .o_ctl, .o_dtr_n,
      .o_rts_n, .o_irq, .o_irq_oe);
   umc_modem_peer i_peer (.i_clk, .i_act(act), .o_modem(i_modem));
   always #20 i_clk = ~i_clk;
   task automatic give_verdict;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      logic [31:0] r;
      r = $random(seed);
      i_avs_write <= w;
      i_avs_read <= !w;
      i_avs_address <= a;
      i_avs_writedata <= {r[31:8], d};
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      @(posedge i_clk);
   endtask : bus
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      q.push_back({24'h0, e});
      bus(1'b0, a, 8'h00);
   endtask : rd
   // read results against the oldest note
   always @(posedge i_clk)
      if (i_avs_read && o_avs_waitrequest === 1'b0)
         check(o_avs_readdata, q.pop_front());
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      i_clk = 1'b0; i_rst = 1'b1; i_avs_read = 1'b0; i_avs_write = 1'b0;
      i_avs_address = 5'h00; i_avs_writedata = 32'h0; xoff = 1'b0;
      i_avs_byteenable = 4'hf; i_clock_divide_select_pin = 1'b0; act = 4'h0; src = 4'h0;
      fr = 8'h01 | (8'h33 & 8'($random(seed)));
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      rd(A_MC, 8'h80);
      rd(A_ID, 8'h01);
      wr(A_MC, 8'hef);
      rd(A_MC, 8'h8f);
      check(o_dtr_n, 1'b0);
      check(o_rts_n, 1'b0);
      check(o_irq_oe, 1'b1);
      wr(A_FT, 8'h5a);
      check(o_ctl.flow_thresh, 8'h00);
      wr(A_IE, 8'hf0);
      rd(A_IE, 8'h00);
      wr(A_EF, 8'h10);
      wr(A_IE, 8'h18);
      rd(A_IE, 8'h18);
      check(o_ctl.sleep_en, 1'b1);
      wr(A_MC, 8'h6f);
      rd(A_MC, 8'h6f);
      check({o_ctl.xon_any, o_ctl.clk_div4}, 2'b10);
      wr(A_FT, 8'ha5);
      check(o_ctl.flow_thresh, 8'ha5);
      wr(A_FS, 8'h01);
      act <= 4'hf;
      repeat (8) @(posedge i_clk);
      check(o_irq, 1'b1);
      rd(A_ID, 8'hc0);
      rd(A_MS, 8'hfb);
      repeat (2) @(posedge i_clk);
      check(o_irq, 1'b0);
      rd(A_ID, 8'hc1);
      act <= 4'h0;
      repeat (8) @(posedge i_clk);
      rd(A_MS, 8'h0f);
      wr(A_IE, 8'h1f);
      src <= 4'hf;
      for (int k = 0; k < 4; k++) begin
         repeat (2) @(posedge i_clk);
         rd(A_ID, {2'b11, ids[k]});
         if (k < 3) src[3-k] <= 1'b0;
      end
      rd(A_ID, 8'hc1);
      wr(A_IE, 8'h1d);
      wr(A_IE, 8'h1f);
      rd(A_ID, 8'hc2);
      src <= 4'h0;
      wr(A_IE, 8'h20);
      xoff <= 1'b1;
      @(posedge i_clk);
      xoff <= 1'b0;
      repeat (2) @(posedge i_clk);
      rd(A_ID, 8'hd0);
      rd(A_ID, 8'hc1);
      wr(A_IE, 8'h40);
      wr(A_EF, 8'h50);
      @(posedge i_clk);
      rd(A_ID, 8'he0);
      check(o_rts_n, 1'b1);
      wr(A_EF, 8'h10);
      wr(A_IE, 8'h80);
      act <= 4'h1;
      repeat (8) @(posedge i_clk);
      rd(A_MS, 8'h11);
      act <= 4'h0;
      repeat (8) @(posedge i_clk);
      rd(A_ID, 8'he0);
      rd(A_MS, 8'h01);
      rd(A_FR, fr);
      wr(A_MC, 8'h74);
      rd(A_FR, 8'h00);
      rd(A_MS, 8'h44);
      check({o_dtr_n, o_rts_n, o_ctl.loopback}, 3'b111);
      wr(A_ID, 8'h3e);
      rd(A_ID, 8'hc1);
      i_rst <= 1'b1;
      i_clock_divide_select_pin <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
      rd(A_MC, 8'h00);
      rd(A_FR, 8'h00);
      give_verdict();
   end
endmodule : umc_modem_ctrl_tb
